// *** testbench/scd_decode_asserts.sv ***
// Checker for the decoder's port behaviour.
// Assumes it is bound onto scd_decode in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module scd_decode_asserts
    import scd_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_instr_valid,
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_instr_addr,
    input wire logic o_instr_ready,
    input wire logic o_pc_load,
    input wire logic [31:0] o_pc_target,
    input wire logic o_svc_trap,
    input wire logic o_und_trap,
    input wire logic o_cop_valid,
    input wire logic [31:0] o_current_status_word,
    input wire logic [31:0] o_supervisor_saved_status,
    input wire logic [31:0] o_supervisor_link_reg,
    input wire logic [31:0] o_undef_saved_status,
    input wire logic [3:0] o_coproc_number_field
);
default clocking @(posedge i_clk_sys); endclocking
default disable iff (i_sys_rst);
wire logic tk = i_instr_valid && o_instr_ready && i_instr[31:28] == 4'hE;
wire logic svc = tk && i_instr[27:24] == CLASS_SVC;
wire logic cop = tk && i_instr[27:24] == CLASS_COP;
svc_vector_a: assert property (o_svc_trap |-> o_pc_load &&
    o_pc_target == VEC_SVC && o_current_status_word[4:0] == MODE_SVC)
    else $error("svc vector wrong");
und_vector_a: assert property (o_und_trap |-> o_pc_load &&
    o_pc_target == VEC_UND && o_current_status_word[4:0] == MODE_UND)
    else $error("undef vector wrong");
svc_link_a: assert property (svc |=> o_svc_trap &&
    o_supervisor_link_reg == $past(i_instr_addr) + WORD_STEP)
    else $error("svc link wrong");
svc_save_a: assert property (svc |=>
    o_supervisor_saved_status == $past(o_current_status_word))
    else $error("svc saved status wrong");
und_save_a: assert property (cop |=>
    o_undef_saved_status == $past(o_current_status_word))
    else $error("undef saved status wrong");
trap_stall_a: assert property (o_svc_trap |->
    !o_instr_ready [*3] ##1 o_instr_ready) else $error("stall wrong");
never_cond_a: assert property (i_instr_valid && o_instr_ready &&
    i_instr[31:28] == 4'hF |=> !o_pc_load) else $error("cond ignored");
cop_fields_a: assert property (cop && !i_instr[CDP_BIT] |=>
    o_cop_valid && o_coproc_number_field == $past(i_instr[11:8]))
    else $error("cop fields wrong");
cop_bit4_a: assert property (cop && i_instr[CDP_BIT] |=>
    o_und_trap && !o_cop_valid) else $error("bit4 decode wrong");
cover property (o_svc_trap);
cover property (o_cop_valid);
cover property (o_und_trap && !o_cop_valid);
endmodule
bind scd_decode scd_decode_asserts u_chk (.*);
`default_nettype wire

// *** testbench/scd_decode_tb.sv ***
// Self-checking bench for scd_decode, scoreboard by note queue.
// Assumes flags stay zero, so condition outcomes follow PASS.
`timescale 1ns/1ps
`default_nettype none
module scd_decode_tb
    import scd_pkg::*;
;
typedef struct {logic [31:0] t, x, w; logic [2:0] k;} scd_note_t;
localparam logic [15:0] PASS = 16'h56AA;
logic i_clk_sys, i_sys_rst, i_instr_valid, o_instr_ready, o_pc_load;
logic o_svc_trap, o_und_trap, o_cop_valid;
logic [31:0] i_instr, i_instr_addr, o_pc_target, o_current_status_word;
logic [31:0] o_supervisor_saved_status, o_supervisor_link_reg;
logic [31:0] o_undef_saved_status, o_undef_link_reg;
logic [3:0] o_coproc_opcode_field, o_coproc_first_operand;
logic [3:0] o_coproc_destination, o_coproc_number_field;
logic [3:0] o_coproc_second_operand;
logic [2:0] o_coproc_info_field;
logic [31:0] st, sl, ss, ul, us;
int failures = 0;
int checks_done = 0;
int c;
scd_note_t q[$];
scd_note_t m;
scd_decode uut (.*);
////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
        failures++;
        $display("FAIL %0t saw %h want %h", $time, s, e);
    end
endtask
task automatic end_of_test;
    if (failures == 0 && checks_done > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
task automatic issue(input logic [31:0] iw, input logic [31:0] ia);
    int n = 0;
    logic p = 1'b0;
    scd_note_t e;
    e = '{32'h0, 32'h0, iw, 3'h0};
    i_instr = iw;
    i_instr_addr = ia;
    i_instr_valid = 1'b1;
    while (o_instr_ready !== 1'b1) begin
        @(posedge i_clk_sys);
        #1;
        n++;
        if (n > 20) begin
            failures++;
            end_of_test();
        end
    end
    if (PASS[iw[31:28]]) begin
        p = 1'b1;
        if (iw[27:24] == CLASS_SVC) begin
            ss = st;
            sl = ia + WORD_STEP;
            st = {st[31:8], 1'b1, st[6:5], MODE_SVC};
            e = '{VEC_SVC, sl, iw, 3'h4};
        end else if (iw[27:24] == CLASS_COP) begin
            us = st;
            ul = ia + WORD_STEP;
            st = {st[31:8], 1'b1, st[6:5], MODE_UND};
            e = '{VEC_UND, ul, iw, {2'h1, ~iw[CDP_BIT]}};
        end else if (iw[27:0] == RET_CODE) begin
            e.t = (st[4:0] == MODE_UND) ? ul : sl;
            st = (st[4:0] == MODE_UND) ? us : ss;
            e.x = st;
        end else
            p = 1'b0;
    end
    if (p)
        q.push_back(e);
    @(posedge i_clk_sys);
    #1;
    if (e.k != 3'h0) begin
        @(posedge i_clk_sys);
        #1;
    end
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
end
initial begin
    forever begin
        @(posedge i_clk_sys);
        #1;
        if (o_pc_load === 1'b1) begin
            chk({31'h0, q.size() > 0}, 32'h1);
            if (q.size() > 0) begin
                m = q.pop_front();
                chk(o_pc_target, m.t);
                chk({o_svc_trap, o_und_trap, o_cop_valid}, m.k);
                chk(m.k[2] ? o_supervisor_link_reg : m.k[1] ?
                    o_undef_link_reg : o_current_status_word, m.x);
                if (m.k[0])
                    chk({o_coproc_opcode_field, o_coproc_first_operand,
                        o_coproc_destination, o_coproc_number_field,
                        o_coproc_info_field, o_coproc_second_operand},
                        {m.w[23:5], m.w[3:0]});
            end
        end
    end
end
initial begin
    i_sys_rst = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = 32'h0;
    i_instr_addr = 32'h0;
    {st, sl, ss, ul, us} = {STATUS_RST, 128'h0};
    void'($urandom(32'hC8D35FBA));
    repeat (16) @(posedge i_clk_sys);
    #1;
    i_sys_rst = 1'b0;
    chk(o_current_status_word, STATUS_RST);
    chk({31'h0, o_instr_ready}, 32'h1);
    for (c = 0; c < 16; c++) begin
        issue({c[3:0], CLASS_SVC, 24'($urandom)}, {30'($urandom), 2'h0});
        issue({4'hE, RET_CODE}, 32'h0);
    end
    issue({4'hE, CLASS_SVC, 24'h0}, 32'h100);
    issue({4'hE, CLASS_SVC, 24'h1}, 32'h200);
    issue({4'hE, RET_CODE}, 32'h0);
    for (c = 0; c < 8; c++) begin
        issue({3'h7, c[0], CLASS_COP, 24'($urandom)}, {30'($urandom), 2'h0});
        issue({4'hE, RET_CODE}, 32'h0);
    end
    issue({4'hE, 4'hA, 24'($urandom)}, 32'h40);
    i_instr_valid = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    chk(32'(q.size()), 32'h0);
    end_of_test();
end
endmodule
`default_nettype wire

// *** verilog/scd_decode.sv ***
// Decode and trap logic for supervisor calls and coprocessor data operations.
// Assumes instructions arrive from fetch on the core clock with a
// valid/ready handshake and that no coprocessor is attached.
//
// Overview of operation
// - Each instruction runs only if its top four condition bits pass.
// - Class bits all ones mark a supervisor call; low 24 bits are comment.
// - A supervisor call enters supervisor mode and jumps to vector 0x08.
// - The status word is saved to the supervisor saved status first.
// - The supervisor link register gets the address of the next word.
// - A flag-setting return move restores program counter and status word.
// - A nested supervisor call simply overwrites link and saved status.
// - The 24-bit comment field is ignored by the core.
// - A supervisor call costs two sequential plus one non-sequential cycle.
// - Every coprocessor instruction that passes takes the undefined trap.
// - A data operation is class 1110 with bit 4 clear.
// - Data operation fields are opcode, operands, dest, number and info.
// - The number field is 0 to 15 and a coprocessor ignores others.
// - The core neither takes a result nor waits for completion.
// - With a coprocessor it would cost one sequential plus busy cycles.
`timescale 1ns/1ps
`default_nettype none

module scd_decode
    import scd_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_instr_valid,
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_instr_addr,
    output logic o_instr_ready,
    output logic o_pc_load,
    output logic [31:0] o_pc_target,
    output logic o_svc_trap,
    output logic o_und_trap,
    output logic [31:0] o_current_status_word,
    output logic [31:0] o_supervisor_saved_status,
    output logic [31:0] o_supervisor_link_reg,
    output logic [31:0] o_undef_saved_status,
    output logic [31:0] o_undef_link_reg,
    output logic o_cop_valid,
    output logic [3:0] o_coproc_opcode_field,
    output logic [3:0] o_coproc_first_operand,
    output logic [3:0] o_coproc_destination,
    output logic [3:0] o_coproc_number_field,
    output logic [2:0] o_coproc_info_field,
    output logic [3:0] o_coproc_second_operand
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic ready;
        logic [1:0] wait_cnt;
        logic pc_load;
        logic [31:0] pc_target;
        logic svc_trap;
        logic und_trap;
        logic [31:0] status;
        logic [31:0] svc_saved;
        logic [31:0] svc_link;
        logic [31:0] und_saved;
        logic [31:0] und_link;
        logic cop_valid;
        logic [3:0] opc;
        logic [3:0] first;
        logic [3:0] dest;
        logic [3:0] num;
        logic [2:0] info;
        logic [3:0] second;
    } scd_state_t;

    scd_state_t state_r;
    scd_state_t state_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Condition check against N Z C V
    function automatic logic cond_pass(input logic [3:0] cond,
                                       input logic [31:0] sw);
        logic n;
        logic z;
        logic c;
        logic v;
        logic res;
        n = sw[FLAG_N];
        z = sw[FLAG_Z];
        c = sw[FLAG_C];
        v = sw[FLAG_V];
        case (cond)
            4'h0: res = z;
            4'h1: res = !z;
            4'h2: res = c;
            4'h3: res = !c;
            4'h4: res = n;
            4'h5: res = !n;
            4'h6: res = v;
            4'h7: res = !v;
            4'h8: res = c && !z;
            4'h9: res = !c || z;
            4'hA: res = (n == v);
            4'hB: res = (n != v);
            4'hC: res = !z && (n == v);
            4'hD: res = z || (n != v);
            4'hE: res = 1'b1;
            default: res = 1'b0;
        endcase
        return res;
    endfunction

    // Status word with a new mode and interrupts masked
    function automatic logic [31:0] enter_mode(input logic [31:0] sw,
                                               input logic [4:0] mode);
        logic [31:0] res;
        res = sw;
        res[MODE_HI:MODE_LO] = mode;
        res[IRQ_OFF] = 1'b1;
        return res;
    endfunction

    // Four-bit field at a given low position
    function automatic logic [3:0] nibble_at(input logic [31:0] word,
                                             input int lo);
        logic [3:0] res;
        res = word[lo +: 4];
        return res;
    endfunction

    // Return bank chosen by the mode being left
    function automatic logic from_undef(input logic [31:0] sw);
        logic res;
        res = (sw[MODE_HI:MODE_LO] == MODE_UND);
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode

    logic take;
    logic pass;
    logic is_svc;
    logic is_cop;
    logic is_cdp;
    logic is_ret;
    logic [31:0] next_word;
    logic [3:0] cond_f;
    logic [3:0] class_f;
    logic [3:0] opc_f;
    logic [3:0] first_f;
    logic [3:0] dest_f;
    logic [3:0] num_f;
    logic [2:0] info_f;
    logic [3:0] second_f;
    logic ret_und;
    logic [31:0] ret_target;
    logic [31:0] ret_status;

    always_comb begin
        cond_f = nibble_at(i_instr, COND_LO);
        class_f = nibble_at(i_instr, CLASS_LO);
        opc_f = nibble_at(i_instr, OPC_LO);
        first_f = nibble_at(i_instr, FIRST_LO);
        dest_f = nibble_at(i_instr, DEST_LO);
        num_f = nibble_at(i_instr, NUM_LO);
        info_f = i_instr[INFO_HI:INFO_LO];
        second_f = nibble_at(i_instr, SECOND_LO);
        take = i_instr_valid && state_r.ready;
        pass = cond_pass(cond_f, state_r.status);
        // Only class bits count; comment field never looked at
        is_svc = (class_f == CLASS_SVC);
        is_cop = (class_f == CLASS_COP);
        is_cdp = is_cop && !i_instr[CDP_BIT];
        is_ret = (i_instr[CLASS_HI:0] == RET_CODE);
        next_word = i_instr_addr + WORD_STEP;
        ret_und = from_undef(state_r.status);
        ret_target = ret_und ? state_r.und_link : state_r.svc_link;
        ret_status = ret_und ? state_r.und_saved : state_r.svc_saved;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_nxt = state_r;
        state_nxt.pc_load = 1'b0;
        state_nxt.svc_trap = 1'b0;
        state_nxt.und_trap = 1'b0;
        state_nxt.cop_valid = 1'b0;
        if (state_r.wait_cnt != 2'h0) begin
            state_nxt.wait_cnt = state_r.wait_cnt - 2'h1;
        end
        if (take && pass) begin
            if (is_svc) begin
                // Nested calls overwrite, no stack kept
                state_nxt.svc_saved = state_r.status;
                state_nxt.svc_link = next_word;
                state_nxt.status = enter_mode(state_r.status,
                                              MODE_SVC);
                state_nxt.pc_target = VEC_SVC;
                state_nxt.pc_load = 1'b1;
                state_nxt.svc_trap = 1'b1;
                state_nxt.wait_cnt = SVC_EXTRA;
            end else if (is_cop) begin
                if (is_cdp) begin
                    // Fields split out, nothing awaited back
                    state_nxt.cop_valid = 1'b1;
                    state_nxt.opc = opc_f;
                    state_nxt.first = first_f;
                    state_nxt.dest = dest_f;
                    state_nxt.num = num_f;
                    state_nxt.info = info_f;
                    state_nxt.second = second_f;
                end
                // No coprocessor answers, so trap to emulation
                state_nxt.und_saved = state_r.status;
                state_nxt.und_link = next_word;
                state_nxt.status = enter_mode(state_r.status,
                                              MODE_UND);
                state_nxt.pc_target = VEC_UND;
                state_nxt.pc_load = 1'b1;
                state_nxt.und_trap = 1'b1;
                state_nxt.wait_cnt = UND_EXTRA;
            end else if (is_ret) begin
                // Return through the bank of the current mode
                state_nxt.pc_load = 1'b1;
                state_nxt.pc_target = ret_target;
                state_nxt.status = ret_status;
            end
        end
        state_nxt.ready = (state_nxt.wait_cnt == 2'h0);
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_r <= '0;
            state_r.ready <= 1'b1;
            state_r.status <= STATUS_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_instr_ready = state_r.ready;
    assign o_pc_load = state_r.pc_load;
    assign o_pc_target = state_r.pc_target;
    assign o_svc_trap = state_r.svc_trap;
    assign o_und_trap = state_r.und_trap;
    assign o_current_status_word = state_r.status;
    assign o_supervisor_saved_status = state_r.svc_saved;
    assign o_supervisor_link_reg = state_r.svc_link;
    assign o_undef_saved_status = state_r.und_saved;
    assign o_undef_link_reg = state_r.und_link;
    assign o_cop_valid = state_r.cop_valid;
    assign o_coproc_opcode_field = state_r.opc;
    assign o_coproc_first_operand = state_r.first;
    assign o_coproc_destination = state_r.dest;
    assign o_coproc_number_field = state_r.num;
    assign o_coproc_info_field = state_r.info;
    assign o_coproc_second_operand = state_r.second;

endmodule

`default_nettype wire

// *** verilog/scd_pkg.sv ***
// Constants for the supervisor call and coprocessor data operation decoder.
// Assumes a 32-bit instruction word and a single core clock domain.
package scd_pkg;

    // Instruction field positions
    localparam int COND_HI = 31;
    localparam int COND_LO = 28;
    localparam int CLASS_HI = 27;
    localparam int CLASS_LO = 24;
    localparam int OPC_HI = 23;
    localparam int OPC_LO = 20;
    localparam int FIRST_HI = 19;
    localparam int FIRST_LO = 16;
    localparam int DEST_HI = 15;
    localparam int DEST_LO = 12;
    localparam int NUM_HI = 11;
    localparam int NUM_LO = 8;
    localparam int INFO_HI = 7;
    localparam int INFO_LO = 5;
    localparam int CDP_BIT = 4;
    localparam int SECOND_HI = 3;
    localparam int SECOND_LO = 0;

    // Class codes
    localparam logic [3:0] CLASS_SVC = 4'hF;
    localparam logic [3:0] CLASS_COP = 4'hE;

    // Flag-setting move of link register into program counter, cond masked
    localparam logic [27:0] RET_CODE = 28'h1B0F00E;

    // Status word layout
    localparam int FLAG_N = 31;
    localparam int FLAG_Z = 30;
    localparam int FLAG_C = 29;
    localparam int FLAG_V = 28;
    localparam int IRQ_OFF = 7;
    localparam int MODE_HI = 4;
    localparam int MODE_LO = 0;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_UND = 5'h1B;
    localparam logic [31:0] STATUS_RST = 32'h0000_00D3;

    // Trap vectors
    localparam logic [31:0] VEC_SVC = 32'h0000_0008;
    localparam logic [31:0] VEC_UND = 32'h0000_0004;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;

    // Extra cycles: supervisor call 2S + 1N, undefined trap likewise
    localparam logic [1:0] SVC_EXTRA = 2'h3;
    localparam logic [1:0] UND_EXTRA = 2'h3;

endpackage
